// ==== core/usbgw_params.svh ====
// Constants of the USB register gateway
`ifndef USBGW_PARAMS_SVH
`define USBGW_PARAMS_SVH
`define USBGW_MAX_PKT 7'd64
`define USBGW_PKT_LAST 7'd63
`define USBGW_BUF_AW 6
`define USBGW_EP_CTL 4'h0
`define USBGW_EP_BIN 4'h2
`define USBGW_EP_BOUT 4'h3
`define USBGW_EP_EVT 4'h4
`define USBGW_RT_RD 8'hc0
`define USBGW_RT_WR 8'h40
`define USBGW_REQ_REG 8'h00
`define USBGW_LEN_RD 16'h0001
`define USBGW_LEN_WR 16'h0000
`define USBGW_RT_STD 2'h0
`define USBGW_RT_VENDOR 2'h2
`define USBGW_SETUP_BYTES 4'h8
`define USBGW_OTG_ID_BIT 0
`define USBGW_CLK_NS 10
`define USBGW_OTG_POLL_NS 1000000
`define USBGW_POLL_W 20
`endif

// ==== core/usbgw_pkg.sv ====
// Types shared by the USB register gateway
package usbgw_pkg;
  typedef enum logic [1:0] {USBGW_MODE_DEV, USBGW_MODE_HOST, USBGW_MODE_OTG} usbgw_mode_t;
  typedef enum logic [1:0] {USBGW_PID_SETUP, USBGW_PID_IN, USBGW_PID_OUT} usbgw_pid_t;
  typedef enum logic [1:0] {USBGW_HS_ACK, USBGW_HS_NAK, USBGW_HS_STALL} usbgw_hs_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_DECODE, ST_RD_WAIT, ST_CTL_RX, ST_OUT_RX,
                            ST_TX, ST_TX_ACK} usbgw_st_t;
  typedef enum logic [1:0] {CTL_NONE, CTL_RD_DATA, CTL_RD_STAT, CTL_WR_STAT} usbgw_ctl_t;
  typedef enum logic [2:0] {BUF_EMPTY, BUF_IN_FILL, BUF_IN_RDY, BUF_OUT_RX,
                            BUF_OUT_DRAIN} usbgw_buf_t;
  typedef enum logic [1:0] {SRC_CTL_BYTE, SRC_ZLP, SRC_BULK, SRC_EVT} usbgw_src_t;
  typedef struct packed {
    logic [15:0] len;
    logic [15:0] idx;
    logic [15:0] val;
    logic [7:0] req;
    logic [7:0] rtype;
  } usbgw_setup_t;
  typedef struct packed {
    usbgw_pid_t pid;
    logic [3:0] ep;
  } usbgw_tok_t;
  typedef struct packed {
    logic zlp;
    logic last;
    logic [7:0] data;
  } usbgw_tx_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } usbgw_reg_req_t;
endpackage

// ==== core/usbgw_pkt_buf.sv ====
// Packet buffer shared by the bulk pipes
`timescale 1ns/1ps
`include "usbgw_params.svh"
module usbgw_pkt_buf
  import usbgw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write side, appends at the fill level
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic clr,
  // Read side, random index
  input wire logic [`USBGW_BUF_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [`USBGW_BUF_AW:0] count
);
  logic [7:0] mem [0:(1<<`USBGW_BUF_AW)-1];
  logic [`USBGW_BUF_AW:0] cnt_q;

  // Fill level, clear wins, never past one packet
  always_ff @(posedge clk) begin
    if (!rst_b || clr) begin
      cnt_q <= '0;
    end else if (wr_en && cnt_q < `USBGW_MAX_PKT) begin
      cnt_q <= cnt_q + 7'd1;
    end
  end

  // Storage array
  always_ff @(posedge clk) begin
    if (wr_en && cnt_q < `USBGW_MAX_PKT) begin
      mem[cnt_q[`USBGW_BUF_AW-1:0]] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
  assign count = cnt_q;
endmodule

// ==== core/usbgw_core.sv ====
// USB device-side pipes, register gateway and role selection
`timescale 1ns/1ps
`include "usbgw_params.svh"
module usbgw_core
  import usbgw_pkg::*;
#(
  parameter int unsigned OTG_POLL_CYCLES = `USBGW_OTG_POLL_NS / `USBGW_CLK_NS
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Mode control
  input wire logic MODE_WR,
  input wire usbgw_mode_t MODE_SEL,
  output usbgw_mode_t MODE,
  output logic HOST_ROLE,
  output logic XCVR_EXT_SEL,
  // External OTG transceiver status
  output logic OTG_STAT_RD,
  input wire logic OTG_STAT_VLD,
  input wire logic [7:0] OTG_STAT,
  // Packet engine, receive side
  input wire logic TOK_VLD,
  input wire usbgw_tok_t TOK,
  input wire logic RX_VLD,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic RX_ERR,
  // Packet engine, transmit side
  output logic TX_VLD,
  output usbgw_tx_t TX_PKT,
  input wire logic TX_RDY,
  input wire logic HOST_ACK,
  input wire logic HOST_TMO,
  output logic HS_VLD,
  output usbgw_hs_t HS_CODE,
  // Internal register access
  output usbgw_reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA,
  output logic STD_REQ_VLD,
  output usbgw_setup_t STD_REQ,
  // Device events
  input wire logic EVT_PEND,
  input wire logic [7:0] EVT_CODE,
  output logic EVT_ACK,
  // DMA toward the host
  input wire logic DMA_IN_VLD,
  input wire logic [7:0] DMA_IN_DATA,
  input wire logic DMA_IN_LAST,
  output logic DMA_IN_RDY,
  // DMA from the host
  output logic DMA_OUT_VLD,
  output logic [7:0] DMA_OUT_DATA,
  output logic DMA_OUT_LAST,
  input wire logic DMA_OUT_RDY
);
  localparam logic [`USBGW_POLL_W-1:0] POLL_LAST = `USBGW_POLL_W'(OTG_POLL_CYCLES - 1);

  usbgw_st_t st_q, st_d;
  usbgw_ctl_t ctl_q, ctl_d;
  usbgw_buf_t bst_q, bst_d;
  usbgw_src_t src_q, src_d;
  usbgw_setup_t setup_q, setup_d;
  usbgw_hs_t hs_code_q, hs_code_d;
  usbgw_reg_req_t reg_req_q, reg_req_d;
  usbgw_mode_t mode_q, mode_d;
  logic [3:0] scnt_q, scnt_d;
  logic [6:0] tx_idx_q, tx_idx_d, drn_idx_q, drn_idx_d, tx_len;
  logic [7:0] rd_byte_q, rd_byte_d;
  logic ovf_q, ovf_d, stall_q, stall_d, hs_vld_q, hs_vld_d;
  logic evt_ack_q, evt_ack_d, std_vld_q, std_vld_d;
  logic role_host_q, otg_rd_q;
  logic [`USBGW_POLL_W-1:0] poll_q;
  logic buf_wr, buf_clr, dma_in_take, dma_out_take, tx_last, dev_act;
  logic [7:0] buf_rd, buf_wdata;
  logic [6:0] buf_cnt;
  logic [5:0] buf_addr;

  //////////////////////////////////////////////////////////////////////////////
  // Token and request decode
  wire tok_setup0 = TOK.pid == USBGW_PID_SETUP && TOK.ep == `USBGW_EP_CTL;
  wire tok_in = TOK.pid == USBGW_PID_IN;
  wire tok_out = TOK.pid == USBGW_PID_OUT;
  wire tok_out_acc = st_q == ST_IDLE && dev_act && TOK_VLD && tok_out &&
                     TOK.ep == `USBGW_EP_BOUT && bst_q == BUF_EMPTY;
  wire vend = setup_q.rtype[6:5] == `USBGW_RT_VENDOR;
  wire std = setup_q.rtype[6:5] == `USBGW_RT_STD;
  wire rd_match = setup_q.rtype == `USBGW_RT_RD && setup_q.req == `USBGW_REQ_REG &&
                  setup_q.len == `USBGW_LEN_RD;
  wire wr_match = setup_q.rtype == `USBGW_RT_WR && setup_q.req == `USBGW_REQ_REG &&
                  setup_q.len == `USBGW_LEN_WR;
  wire blocked_hs = stall_q ? 1'b1 : 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Buffer steering and transmit selection
  assign dev_act = mode_q == USBGW_MODE_DEV || (mode_q == USBGW_MODE_OTG && !role_host_q);
  assign DMA_IN_RDY = (bst_q == BUF_IN_FILL || (bst_q == BUF_EMPTY && !tok_out_acc)) &&
                      buf_cnt < `USBGW_MAX_PKT;
  assign dma_in_take = DMA_IN_VLD && DMA_IN_RDY;
  assign DMA_OUT_VLD = bst_q == BUF_OUT_DRAIN;
  assign dma_out_take = DMA_OUT_VLD && DMA_OUT_RDY;
  assign DMA_OUT_DATA = buf_rd;
  assign DMA_OUT_LAST = drn_idx_q + 7'd1 == buf_cnt && buf_cnt < `USBGW_MAX_PKT;
  assign buf_wdata = bst_q == BUF_OUT_RX ? RX_DATA : DMA_IN_DATA;
  assign buf_addr = bst_q == BUF_OUT_DRAIN ? drn_idx_q[5:0] : tx_idx_q[5:0];
  assign tx_len = src_q == SRC_BULK ? buf_cnt : (src_q == SRC_ZLP ? 7'd0 : 7'd1);
  assign tx_last = src_q == SRC_ZLP || tx_idx_q + 7'd1 == tx_len;
  assign TX_VLD = st_q == ST_TX;
  assign TX_PKT.zlp = src_q == SRC_ZLP;
  assign TX_PKT.last = tx_last;
  assign TX_PKT.data = src_q == SRC_BULK ? buf_rd :
                       (src_q == SRC_EVT ? EVT_CODE :
                       (src_q == SRC_CTL_BYTE ? rd_byte_q : 8'h00));

  usbgw_pkt_buf u_buf (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .wr_en(buf_wr || dma_in_take),
    .wr_data(buf_wdata),
    .clr(buf_clr),
    .rd_addr(buf_addr),
    .rd_data(buf_rd),
    .count(buf_cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic for pipes and control transfers
  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    bst_d = bst_q;
    src_d = src_q;
    setup_d = setup_q;
    scnt_d = scnt_q;
    tx_idx_d = tx_idx_q;
    drn_idx_d = drn_idx_q;
    rd_byte_d = rd_byte_q;
    ovf_d = ovf_q;
    stall_d = stall_q;
    hs_vld_d = 1'b0;
    hs_code_d = hs_code_q;
    reg_req_d = '0;
    evt_ack_d = 1'b0;
    std_vld_d = 1'b0;
    buf_wr = 1'b0;
    buf_clr = 1'b0;
    // Fill from DMA until full or last byte
    if (dma_in_take) begin
      bst_d = (DMA_IN_LAST || buf_cnt == `USBGW_PKT_LAST) ? BUF_IN_RDY : BUF_IN_FILL;
    end
    // Drain to DMA, buffer freed after last byte
    if (dma_out_take) begin
      drn_idx_d = drn_idx_q + 7'd1;
      if (drn_idx_q + 7'd1 == buf_cnt) begin
        buf_clr = 1'b1;
        bst_d = BUF_EMPTY;
        drn_idx_d = '0;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (TOK_VLD && dev_act) begin
          hs_vld_d = 1'b1;
          hs_code_d = USBGW_HS_NAK;
          tx_idx_d = '0;
          if (tok_setup0) begin
            hs_vld_d = 1'b0;
            st_d = ST_SETUP;
            scnt_d = '0;
            ctl_d = CTL_NONE;
            stall_d = 1'b0;
          end else if (TOK.ep == `USBGW_EP_CTL && blocked_hs) begin
            hs_code_d = USBGW_HS_STALL;
          end else if (TOK.ep == `USBGW_EP_CTL && tok_in && ctl_q == CTL_RD_DATA) begin
            hs_vld_d = 1'b0;
            src_d = SRC_CTL_BYTE;
            st_d = ST_TX;
          end else if (TOK.ep == `USBGW_EP_CTL && tok_in && ctl_q == CTL_WR_STAT) begin
            hs_vld_d = 1'b0;
            src_d = SRC_ZLP;
            st_d = ST_TX;
          end else if (TOK.ep == `USBGW_EP_CTL && tok_out && ctl_q == CTL_RD_STAT) begin
            hs_vld_d = 1'b0;
            st_d = ST_CTL_RX;
          end else if (TOK.ep == `USBGW_EP_BIN && tok_in) begin
            if (bst_q == BUF_IN_RDY) begin
              hs_vld_d = 1'b0;
              src_d = SRC_BULK;
              st_d = ST_TX;
            end
          end else if (TOK.ep == `USBGW_EP_BOUT && tok_out) begin
            if (tok_out_acc) begin
              hs_vld_d = 1'b0;
              bst_d = BUF_OUT_RX;
              ovf_d = 1'b0;
              st_d = ST_OUT_RX;
            end
          end else if (TOK.ep == `USBGW_EP_EVT && tok_in) begin
            if (EVT_PEND) begin
              hs_vld_d = 1'b0;
              src_d = SRC_EVT;
              st_d = ST_TX;
            end
          end else if (TOK.ep != `USBGW_EP_CTL) begin
            hs_code_d = USBGW_HS_STALL;
          end
        end
      end
      ST_SETUP: begin
        if (RX_VLD && scnt_q < `USBGW_SETUP_BYTES) begin
          setup_d = {RX_DATA, setup_q[63:8]};
          scnt_d = scnt_q + 4'h1;
        end
        if (RX_END) begin
          st_d = ST_IDLE;
          if (!RX_ERR && scnt_q == `USBGW_SETUP_BYTES) begin
            hs_vld_d = 1'b1;
            hs_code_d = USBGW_HS_ACK;
            st_d = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        st_d = ST_IDLE;
        if (vend && rd_match) begin
          reg_req_d.rd = 1'b1;
          reg_req_d.addr = setup_q.idx;
          st_d = ST_RD_WAIT;
        end else if (vend && wr_match) begin
          reg_req_d.wr = 1'b1;
          reg_req_d.addr = setup_q.idx;
          reg_req_d.wdata = setup_q.val[7:0];
          ctl_d = CTL_WR_STAT;
        end else if (std) begin
          std_vld_d = 1'b1;
          ctl_d = setup_q.len == `USBGW_LEN_WR ? CTL_WR_STAT : CTL_NONE;
        end else begin
          stall_d = 1'b1;
        end
      end
      ST_RD_WAIT: begin
        rd_byte_d = REG_RDATA;
        ctl_d = CTL_RD_DATA;
        st_d = ST_IDLE;
      end
      ST_CTL_RX: begin
        if (RX_END) begin
          st_d = ST_IDLE;
          if (!RX_ERR) begin
            hs_vld_d = 1'b1;
            hs_code_d = USBGW_HS_ACK;
            ctl_d = CTL_NONE;
          end
        end
      end
      ST_OUT_RX: begin
        if (RX_VLD) begin
          buf_wr = buf_cnt < `USBGW_MAX_PKT;
          ovf_d = ovf_q || buf_cnt == `USBGW_MAX_PKT;
        end
        if (RX_END) begin
          st_d = ST_IDLE;
          if (RX_ERR || ovf_q || buf_cnt == '0) begin
            buf_clr = 1'b1;
            bst_d = BUF_EMPTY;
          end else begin
            bst_d = BUF_OUT_DRAIN;
            drn_idx_d = '0;
          end
          hs_vld_d = !RX_ERR;
          hs_code_d = ovf_q ? USBGW_HS_STALL : USBGW_HS_ACK;
        end
      end
      ST_TX: begin
        if (TX_RDY) begin
          if (tx_last) begin
            st_d = ST_TX_ACK;
          end else begin
            tx_idx_d = tx_idx_q + 7'd1;
          end
        end
      end
      ST_TX_ACK: begin
        if (HOST_ACK) begin
          st_d = ST_IDLE;
          case (src_q)
            SRC_CTL_BYTE: ctl_d = CTL_RD_STAT;
            SRC_ZLP: ctl_d = CTL_NONE;
            SRC_BULK: begin
              buf_clr = 1'b1;
              bst_d = BUF_EMPTY;
            end
            default: evt_ack_d = 1'b1;
          endcase
        end else if (HOST_TMO) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_q <= ST_IDLE;
      ctl_q <= CTL_NONE;
      bst_q <= BUF_EMPTY;
      src_q <= SRC_CTL_BYTE;
      setup_q <= '0;
      scnt_q <= '0;
      tx_idx_q <= '0;
      drn_idx_q <= '0;
      rd_byte_q <= '0;
      {ovf_q, stall_q, hs_vld_q, evt_ack_q, std_vld_q} <= '0;
      hs_code_q <= USBGW_HS_ACK;
      reg_req_q <= '0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      bst_q <= bst_d;
      src_q <= src_d;
      setup_q <= setup_d;
      scnt_q <= scnt_d;
      tx_idx_q <= tx_idx_d;
      drn_idx_q <= drn_idx_d;
      rd_byte_q <= rd_byte_d;
      {ovf_q, stall_q, hs_vld_q, evt_ack_q, std_vld_q} <=
        {ovf_d, stall_d, hs_vld_d, evt_ack_d, std_vld_d};
      hs_code_q <= hs_code_d;
      reg_req_q <= reg_req_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode, role and OTG status polling
  // Mode taken this cycle, so in device and host modes the role never lags the mode; in OTG mode the role waits for OTG_STAT_VLD
  assign mode_d = (MODE_WR && MODE_SEL != 2'h3) ? MODE_SEL : mode_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      mode_q <= USBGW_MODE_DEV;
      role_host_q <= 1'b0;
      poll_q <= '0;
      otg_rd_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      otg_rd_q <= mode_q == USBGW_MODE_OTG && poll_q == POLL_LAST;
      poll_q <= (mode_q != USBGW_MODE_OTG || poll_q == POLL_LAST) ? '0 : poll_q + 1'b1;
      if (mode_d != USBGW_MODE_OTG) begin
        role_host_q <= mode_d == USBGW_MODE_HOST;
      end else if (OTG_STAT_VLD) begin
        role_host_q <= !OTG_STAT[`USBGW_OTG_ID_BIT];
      end
    end
  end

  assign MODE = mode_q;
  assign HOST_ROLE = role_host_q;
  assign XCVR_EXT_SEL = mode_q == USBGW_MODE_OTG;
  assign OTG_STAT_RD = otg_rd_q;
  assign HS_VLD = hs_vld_q;
  assign HS_CODE = hs_code_q;
  assign REG_REQ = reg_req_q;
  assign STD_REQ_VLD = std_vld_q;
  assign STD_REQ = setup_q;
  assign EVT_ACK = evt_ack_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_mode_wr;
    @(posedge CLK_SYS) disable iff (!RST_B)
    MODE_WR && MODE_SEL != 2'h3 |=> MODE == $past(MODE_SEL);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode not taken");

  property p_reset_dev;
    @(posedge CLK_SYS) $past(!RST_B) && RST_B |-> MODE == USBGW_MODE_DEV && !HOST_ROLE;
  endproperty
  a_reset_dev: assert property (p_reset_dev) else $error("not device after reset");

  property p_xcvr;
    @(posedge CLK_SYS) disable iff (!RST_B)
    MODE == USBGW_MODE_DEV |-> !XCVR_EXT_SEL && !HOST_ROLE;
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("wrong transceiver or role");

  property p_bad_ep;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q == ST_IDLE && dev_act && TOK_VLD && TOK.ep > `USBGW_EP_EVT
      |=> HS_VLD && HS_CODE == USBGW_HS_STALL;
  endproperty
  a_bad_ep: assert property (p_bad_ep) else $error("bad pipe not stalled");

  property p_max_pkt;
    @(posedge CLK_SYS) disable iff (!RST_B)
    TX_VLD |-> tx_idx_q < `USBGW_MAX_PKT && buf_cnt <= `USBGW_MAX_PKT;
  endproperty
  a_max_pkt: assert property (p_max_pkt) else $error("packet over limit");

  property p_rd_req;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q == ST_DECODE && vend && rd_match
      |=> REG_REQ.rd && REG_REQ.addr == $past(setup_q.idx) ##2 ctl_q == CTL_RD_DATA;
  endproperty
  a_rd_req: assert property (p_rd_req) else $error("register read mishandled");

  property p_rd_byte;
    @(posedge CLK_SYS) disable iff (!RST_B)
    TX_VLD && src_q == SRC_CTL_BYTE |-> TX_PKT.last && TX_PKT.data == rd_byte_q;
  endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("read data stage wrong");

  property p_wr_req;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q == ST_DECODE && vend && wr_match
      |=> REG_REQ.wr && REG_REQ.wdata == $past(setup_q.val[7:0]) &&
          REG_REQ.addr == $past(setup_q.idx);
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("register write mishandled");

  property p_stall;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q == ST_DECODE && vend && !rd_match && !wr_match |=> stall_q && !REG_REQ.rd;
  endproperty
  a_stall: assert property (p_stall) else $error("bad vendor request not stalled");

  property p_fill;
    @(posedge CLK_SYS) disable iff (!RST_B)
    dma_in_take |=> buf_cnt == $past(buf_cnt) + 7'd1;
  endproperty
  a_fill: assert property (p_fill) else $error("fill byte lost");

  property p_evt;
    @(posedge CLK_SYS) disable iff (!RST_B)
    st_q == ST_TX_ACK && src_q == SRC_EVT && HOST_ACK |=> EVT_ACK ##1 !EVT_ACK;
  endproperty
  a_evt: assert property (p_evt) else $error("event not acknowledged");

  property p_otg_role;
    @(posedge CLK_SYS) disable iff (!RST_B)
    MODE == USBGW_MODE_OTG && !MODE_WR && OTG_STAT_VLD
      |=> HOST_ROLE == !$past(OTG_STAT[`USBGW_OTG_ID_BIT]);
  endproperty
  a_otg_role: assert property (p_otg_role) else $error("role not from ID");
endmodule

// ==== verif/usbgw_host_model.sv ====
// Host-side packet engine model facing the gateway core
`timescale 1ns/1ps
module usbgw_host_model
  import usbgw_pkg::*;
(
  // Clock
  input wire logic clk,
  // Tokens and data toward the device
  output logic tok_vld,
  output usbgw_tok_t tok,
  output logic rx_vld,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_err,
  // Packets from the device
  input wire logic tx_vld,
  input wire usbgw_tx_t tx_pkt,
  output logic tx_rdy,
  output logic host_ack
);
  logic [15:0] tx_q[$];
  logic ack_due = 1'b0;
  int acks = 0;
  // Idle levels at time zero
  initial begin
    tok_vld = 1'b0;
    tok = '0;
    rx_vld = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_err = 1'b0;
    tx_rdy = 1'b0;
    host_ack = 1'b0;
  end
  // Take device bytes, note a final byte for acknowledge
  always @(posedge clk) begin
    ack_due <= tx_vld && tx_rdy && tx_pkt.last;
    if (tx_vld && tx_rdy) begin
      tx_q.push_back({6'h0, tx_pkt});
    end
  end
  // Random stalls and the acknowledge pulse
  always @(negedge clk) begin
    tx_rdy <= ($urandom_range(0, 3) != 0);
    host_ack <= ack_due;
    acks <= acks + ack_due;
  end
  // One token, endpoint field scrambled once released
  task automatic token(input usbgw_pid_t pid, input logic [3:0] ep);
    @(negedge clk);
    tok_vld <= 1'b1;
    tok <= {pid, ep};
    @(negedge clk);
    tok_vld <= 1'b0;
    tok.ep <= ~ep;
  endtask
  // Data packet, one byte a cycle, then end marker
  task automatic data(input logic [7:0] q[$], input logic err);
    foreach (q[i]) begin
      @(negedge clk);
      rx_vld <= 1'b1;
      rx_data <= q[i];
    end
    @(negedge clk);
    rx_vld <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    rx_err <= err;
    @(negedge clk);
    rx_end <= 1'b0;
    rx_err <= 1'b0;
  endtask
endmodule

// ==== verif/tb_usbgw_core.sv ====
// Self-checking bench for the gateway core
`timescale 1ns/1ps
module tb_usbgw_core;
  import usbgw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic mode_wr = 1'b0;
  usbgw_mode_t mode_sel = USBGW_MODE_DEV;
  usbgw_mode_t mode;
  logic host_role, xcvr_ext_sel, otg_stat_rd, tok_vld, rx_vld, rx_end, rx_err, tx_vld, tx_rdy;
  logic host_ack, hs_vld, std_req_vld, evt_ack, dma_in_rdy, dma_out_vld, dma_out_last;
  logic otg_stat_vld = 1'b0, evt_pend = 1'b0, dma_in_vld = 1'b0, dma_in_last = 1'b0;
  logic dma_out_rdy = 1'b0, rd;
  logic [7:0] otg_stat = 8'hff, reg_rdata = 8'h00, evt_code = 8'h00, dma_in_data = 8'h00;
  logic [7:0] rx_data, dma_out_data;
  logic [7:0] b[$];
  logic [15:0] hs_q[$], dma_q[$], exp_q[$], a, v;
  logic [3:0] eps[4] = '{4'h1, 4'h5, 4'h2, 4'h4};
  usbgw_tok_t tok;
  usbgw_tx_t tx_pkt;
  usbgw_hs_t hs_code;
  usbgw_reg_req_t reg_req, last_req;
  usbgw_setup_t std_req, last_std;
  int error_cnt = 0, tests_run = 0, cycles = 0, rd_polls = 0, evts = 0, n;

  always #5 clk_sys = ~clk_sys;

  usbgw_host_model u_host (.clk(clk_sys), .tok_vld(tok_vld), .tok(tok), .rx_vld(rx_vld),
    .rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err), .tx_vld(tx_vld), .tx_pkt(tx_pkt),
    .tx_rdy(tx_rdy), .host_ack(host_ack));

  usbgw_core #(.OTG_POLL_CYCLES(16)) u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .MODE_WR(mode_wr), .MODE_SEL(mode_sel), .MODE(mode), .HOST_ROLE(host_role),
    .XCVR_EXT_SEL(xcvr_ext_sel), .OTG_STAT_RD(otg_stat_rd), .OTG_STAT_VLD(otg_stat_vld),
    .OTG_STAT(otg_stat), .TOK_VLD(tok_vld), .TOK(tok), .RX_VLD(rx_vld), .RX_DATA(rx_data),
    .RX_END(rx_end), .RX_ERR(rx_err), .TX_VLD(tx_vld), .TX_PKT(tx_pkt), .TX_RDY(tx_rdy),
    .HOST_ACK(host_ack), .HOST_TMO(1'b0), .HS_VLD(hs_vld), .HS_CODE(hs_code),
    .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .STD_REQ_VLD(std_req_vld), .STD_REQ(std_req),
    .EVT_PEND(evt_pend), .EVT_CODE(evt_code), .EVT_ACK(evt_ack), .DMA_IN_VLD(dma_in_vld),
    .DMA_IN_DATA(dma_in_data), .DMA_IN_LAST(dma_in_last), .DMA_IN_RDY(dma_in_rdy),
    .DMA_OUT_VLD(dma_out_vld), .DMA_OUT_DATA(dma_out_data), .DMA_OUT_LAST(dma_out_last),
    .DMA_OUT_RDY(dma_out_rdy));

  // Observers of pulses and drained bytes, plus the hang limit
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (hs_vld) hs_q.push_back({14'h0, hs_code});
    if (reg_req.rd || reg_req.wr) last_req <= reg_req;
    if (std_req_vld) last_std <= std_req;
    if (otg_stat_rd) rd_polls <= rd_polls + 1;
    if (evt_ack) evts <= evts + 1;
    if (dma_out_vld && dma_out_rdy) dma_q.push_back({7'h0, dma_out_last, dma_out_data});
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // Drain side stalls at random
  always @(negedge clk_sys) dma_out_rdy <= $urandom_range(0, 1);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Empty queue yields unknown, so a missing event matches only an expected unknown
  function automatic logic [15:0] pop(ref logic [15:0] q[$]);
    return (q.size() != 0) ? q.pop_front() : 16'hxxxx;
  endfunction
  task automatic drain(ref logic [15:0] q[$]);
    while (exp_q.size() != 0) check(pop(q), exp_q.pop_front());
    check(16'(q.size()), 16'h0);
  endtask
  task automatic setup(input logic [7:0] rt, rq, input logic [15:0] sv, ix, ln);
    b = '{rt, rq, sv[7:0], sv[15:8], ix[7:0], ix[15:8], ln[7:0], ln[15:8]};
    u_host.token(USBGW_PID_SETUP, 4'h0);
    u_host.data(b, 1'b0);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic in_tok(input logic [3:0] ep);
    int a0, h0;
    a0 = u_host.acks;
    h0 = hs_q.size();
    u_host.token(USBGW_PID_IN, ep);
    for (int i = 0; i < 300 && u_host.acks == a0 && hs_q.size() == h0; i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(negedge clk_sys);
    mode_wr = 1'b1;
    mode_sel = usbgw_mode_t'(m);
    @(negedge clk_sys);
    mode_wr = 1'b0;
  endtask
  task automatic otg_id(input logic [7:0] s);
    @(negedge clk_sys);
    otg_stat_vld = 1'b1;
    otg_stat = s;
    @(negedge clk_sys);
    otg_stat_vld = 1'b0;
    otg_stat = ~s;
    @(negedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(1927));
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    check({mode, host_role, xcvr_ext_sel, dma_in_rdy, tx_vld}, {USBGW_MODE_DEV, 4'h2});
    // Register writes and reads, each with its status stage
    for (int k = 0; k < 4; k++) begin
      a = 16'($urandom);
      v = 16'($urandom);
      reg_rdata = v[15:8];
      rd = k[0];
      setup(rd ? 8'hc0 : 8'h40, 8'h00, v, a, {15'h0, rd});
      check(pop(hs_q), 16'h0);
      check(last_req.addr, a);
      check({last_req.rd, last_req.wr}, {rd, ~rd});
      if (!rd) check(last_req.wdata, v[7:0]);
      in_tok(4'h0);
      exp_q = '{rd ? {8'h01, v[15:8]} : 16'h0300};
      drain(u_host.tx_q);
      if (rd) begin
        b = {};
        u_host.token(USBGW_PID_OUT, 4'h0);
        u_host.data(b, 1'b0);
        repeat (3) @(negedge clk_sys);
        check(pop(hs_q), 16'h0);
      end
    end
    // Standard request without data stage
    setup(8'h00, 8'h09, 16'h0001, 16'h0, 16'h0);
    check(pop(hs_q), 16'h0);
    check({last_std.req, last_std.val[7:0]}, 16'h0901);
    in_tok(4'h0);
    exp_q = '{16'h0300};
    drain(u_host.tx_q);
    // Malformed vendor forms, unknown and empty pipes
    setup(8'h40, 8'h01, 16'h0, 16'h0, 16'h0);
    in_tok(4'h0);
    setup(8'hc0, 8'h00, 16'h0, 16'h0, 16'h2);
    in_tok(4'h0);
    foreach (eps[i]) in_tok(eps[i]);
    exp_q = '{16'h0, 16'h2, 16'h0, 16'h2, 16'h2, 16'h2, 16'h1, 16'h1};
    drain(hs_q);
    // Bulk-out: short, full, oversize, corrupted
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? $urandom_range(1, 63) : (k == 1) ? 64 : (k == 2) ? 65 : 5;
      b = {};
      exp_q = {};
      for (int i = 0; i < n; i++) begin
        b.push_back(8'($urandom));
        if (k < 2) exp_q.push_back({7'h0, i == n - 1 && n < 64, b[i]});
      end
      u_host.token(USBGW_PID_OUT, 4'h3);
      u_host.data(b, k == 3);
      for (int i = 0; i < 400 && dma_q.size() < exp_q.size(); i++) @(negedge clk_sys);
      repeat (3) @(negedge clk_sys);
      drain(dma_q);
      check(pop(hs_q), (k == 3) ? 16'hxxxx : (k == 2) ? 16'h2 : 16'h0);
    end
    // Bulk-in: short and full packets staged by the DMA side
    for (int k = 0; k < 2; k++) begin
      n = k ? 64 : $urandom_range(1, 63);
      exp_q = {};
      for (int i = 0; i < n; i++) begin
        @(negedge clk_sys);
        dma_in_vld = 1'b1;
        dma_in_data = 8'($urandom);
        dma_in_last = (i == n - 1);
        exp_q.push_back({7'h0, i == n - 1, dma_in_data});
        for (int w = 0; w < 50 && dma_in_rdy !== 1'b1; w++) @(negedge clk_sys);
      end
      @(negedge clk_sys);
      dma_in_vld = 1'b0;
      dma_in_data = ~dma_in_data;
      in_tok(4'h2);
      drain(u_host.tx_q);
    end
    // Event pipe
    evt_pend = 1'b1;
    evt_code = 8'($urandom);
    in_tok(4'h4);
    evt_pend = 1'b0;
    exp_q = '{{8'h01, evt_code}};
    drain(u_host.tx_q);
    check(16'(evts), 16'h1);
    // Modes and the dual-role choice
    set_mode(2'd1);
    in_tok(4'h2);
    check({mode, host_role, xcvr_ext_sel}, {USBGW_MODE_HOST, 2'b10});
    check(16'(hs_q.size()), 16'h0);
    set_mode(2'd3);
    check(mode, USBGW_MODE_HOST);
    set_mode(2'd2);
    repeat (48) @(negedge clk_sys);
    check(16'(rd_polls > 1 && rd_polls < 5), 16'h1);
    otg_id(8'h01);
    in_tok(4'h2);
    check(16'(host_role), 16'h0);
    check(pop(hs_q), 16'h1);
    otg_id(8'hfe);
    check({host_role, xcvr_ext_sel}, 2'b11);
    set_mode(2'd0);
    check({mode, host_role, xcvr_ext_sel}, {USBGW_MODE_DEV, 2'b00});
    tally_and_finish();
  end
endmodule
